// ==== core/ffpq_top.sv ====
// Fast factory program sequencer with status word and query read path.
// Assumes host writes/reads are single-cycle strobes synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module ffpq_top #(
  parameter int ADDR_W = 24,
  parameter int BLOCK_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  input wire logic program_supply_high_level,
  input wire logic block_locked,
  input wire logic [15:0] array_rdata,
  output logic array_we,
  output logic [ADDR_W-1:0] array_addr,
  output logic [15:0] array_wdata
);
  import ffpq_pkg::*;

  typedef enum {FFPQ_IDLE, FFPQ_SETUP, FFPQ_FAIL, FFPQ_LOAD, FFPQ_PROG, FFPQ_EXIT, FFPQ_DONE} ffpq_state_t;
  ffpq_state_t state_q;
  ffpq_out_t out_q;
  logic [15:0] buf_q [BUF_WORDS];
  logic [5:0] cnt_q;
  logic [5:0] pidx_q;
  logic [7:0] tmr_q;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] paddr_q;
  logic supply_err_q;
  logic locked_q;
  logic [15:0] qdata;
  logic [7:0] status_word;
  logic same_block;
  logic data_wr;

  assign same_block = addr[ADDR_W-1:BLOCK_W] == base_q[ADDR_W-1:BLOCK_W];
  // Buffer data only counts while the stream is open
  // An all-ones word at the first address is data: only an out-of-block all-ones write ends the phase
  assign data_wr = wr_en && state_q == FFPQ_LOAD && addr == base_q;

  // Status word: ready in bit 7, errors in 3 and 1, stream busy in 0
  always_comb begin
    status_word = 8'h00;
    status_word[SB_READY] = state_q == FFPQ_FAIL || state_q == FFPQ_DONE || state_q == FFPQ_IDLE;
    status_word[SB_SUPPLY_ERR] = supply_err_q;
    status_word[SB_LOCKED] = locked_q;
    status_word[SB_BUSY] = state_q == FFPQ_PROG || state_q == FFPQ_EXIT;
  end

  // Sequencer; the confirm write is checked in the cycle it arrives so errors are known when the host first polls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FFPQ_IDLE;
      base_q <= '0;
      supply_err_q <= 1'b0;
      locked_q <= 1'b0;
      tmr_q <= 8'h00;
    end else begin
      case (state_q)
        FFPQ_IDLE: if (wr_en && wdata == CMD_FFP) begin
          state_q <= FFPQ_SETUP;
          base_q <= addr;
          supply_err_q <= 1'b0;
          locked_q <= 1'b0;
        end
        FFPQ_SETUP: if (wr_en) begin
          if (wdata == CMD_FFP && addr == base_q) begin
            if (!program_supply_high_level || block_locked) begin
              state_q <= FFPQ_FAIL;
              supply_err_q <= !program_supply_high_level;
              locked_q <= block_locked;
            end else begin
              state_q <= FFPQ_LOAD;
            end
          end else begin
            state_q <= FFPQ_IDLE;
          end
        end
        FFPQ_FAIL, FFPQ_DONE: if (wr_en) begin
          state_q <= FFPQ_IDLE;
        end
        FFPQ_LOAD: begin
          if (wr_en && wdata == CMD_EXIT && !same_block) begin
            state_q <= FFPQ_EXIT;
            tmr_q <= 8'(EXIT_CYCLES);
          end else if (data_wr && cnt_q == 6'(BUF_WORDS - 1)) begin
            state_q <= FFPQ_PROG;
            tmr_q <= 8'(PROG_CYCLES);
          end
        end
        FFPQ_PROG: begin
          if (tmr_q != 8'h00) begin
            tmr_q <= tmr_q - 8'h01;
          end else if (pidx_q == 6'(BUF_WORDS - 1)) begin
            state_q <= FFPQ_LOAD;
          end else begin
            tmr_q <= 8'(PROG_CYCLES);
          end
        end
        FFPQ_EXIT: begin
          if (tmr_q != 8'h00) begin
            tmr_q <= tmr_q - 8'h01;
          end else begin
            state_q <= FFPQ_DONE;
          end
        end
        default: state_q <= FFPQ_IDLE;
      endcase
    end
  end

  // Buffer load count and storage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
    end else if (state_q != FFPQ_LOAD) begin
      cnt_q <= 6'h00;
    end else if (data_wr) begin
      cnt_q <= (cnt_q == 6'(BUF_WORDS - 1)) ? 6'h00 : cnt_q + 6'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (data_wr) begin
      buf_q[cnt_q[4:0]] <= wdata;
    end
  end

  // Array programming: one word per timer expiry, address advances itself
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pidx_q <= 6'h00;
      paddr_q <= '0;
      array_we <= 1'b0;
      array_addr <= '0;
      array_wdata <= 16'h0000;
    end else begin
      array_we <= 1'b0;
      if (state_q == FFPQ_SETUP) begin
        paddr_q <= base_q;
      end
      if (state_q != FFPQ_PROG) begin
        pidx_q <= 6'h00;
      end else if (tmr_q == 8'h00) begin
        array_we <= 1'b1;
        array_addr <= paddr_q;
        array_wdata <= buf_q[pidx_q[4:0]];
        paddr_q <= paddr_q + 1'b1;
        pidx_q <= pidx_q + 6'h01;
      end
    end
  end

  // Output selection; read array is honoured once the sequencer has settled, other sequence writes force status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= FFPQ_OUT_ARRAY;
    end else if (wr_en) begin
      if (wdata == CMD_QUERY && state_q == FFPQ_IDLE) begin
        out_q <= FFPQ_OUT_QUERY;
      end else if (wdata == CMD_READ_ARRAY && (state_q == FFPQ_IDLE || state_q == FFPQ_FAIL || state_q == FFPQ_DONE)) begin
        out_q <= FFPQ_OUT_ARRAY;
      end else if (wdata == CMD_READ_STATUS || wdata == CMD_FFP || state_q != FFPQ_IDLE) begin
        out_q <= FFPQ_OUT_STATUS;
      end
    end
  end

  ffpq_query_rom ffpq_query_rom_inst (
    .qaddr(addr[7:0]),
    .qdata(qdata)
  );

  // Registered read data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      case (out_q)
        FFPQ_OUT_QUERY: rdata <= qdata;
        FFPQ_OUT_STATUS: rdata <= {8'h00, status_word};
        default: rdata <= array_rdata;
      endcase
    end
  end

  // Last committed address, so the order check also spans the step from one buffer into the next
  logic [ADDR_W-1:0] last_we_addr_q;
  logic seen_we_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_we_addr_q <= '0;
      seen_we_q <= 1'b0;
    end else if (state_q == FFPQ_SETUP) begin
      seen_we_q <= 1'b0;
    end else if (array_we) begin
      last_we_addr_q <= array_addr;
      seen_we_q <= 1'b1;
    end
  end

  // Checks on discard, busy, address order, exit, lock error, stream ready and query output
  a_discard_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_en && status_word[SB_BUSY]) |=> $stable(cnt_q)) else $error("data accepted while busy");
  a_busy_prog: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (data_wr && cnt_q == 6'(BUF_WORDS - 1)) |=> status_word[SB_BUSY]) else $error("busy not raised");
  a_addr_incr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (array_we && seen_we_q) |-> array_addr == last_we_addr_q + 1'b1) else $error("address skip");
  a_exit_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == FFPQ_EXIT) |-> !status_word[SB_READY] ##[1:10] status_word[SB_READY])
    else $error("exit never completes");
  a_query_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_en && out_q == FFPQ_OUT_QUERY) |=> rdata[15:8] == 8'h00) else $error("upper byte nonzero");
  a_query_q: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_en && out_q == FFPQ_OUT_QUERY && addr[7:0] == 8'h10) |=> rdata == 16'h0051) else $error("bad Q");
  a_lock_err: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == FFPQ_SETUP && wr_en && wdata == CMD_FFP && addr == base_q && block_locked)
    |=> status_word[SB_READY] && status_word[SB_LOCKED]) else $error("lock error missing");
  a_stream_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == FFPQ_PROG && tmr_q == 8'h00 && pidx_q == 6'(BUF_WORDS - 1))
    |=> !status_word[SB_BUSY] && !status_word[SB_READY]) else $error("stream not ready");
  c_buffer_full: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == FFPQ_PROG);
  c_setup_fail: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == FFPQ_FAIL);
  c_exit_done: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == FFPQ_DONE);
  c_query_read: cover property (@(posedge clk_sys) disable iff (!rst_n) rd_en && out_q == FFPQ_OUT_QUERY);
endmodule : ffpq_top
`default_nettype wire

// ==== inc/ffpq_pkg.sv ====
// Package for the fast-program sequencer and query database of a parallel NOR flash.
// Assumes a 16-bit command/data bus sampled synchronously with clk_sys.
package ffpq_pkg;
  localparam logic [15:0] CMD_FFP = 16'h0080;
  localparam logic [15:0] CMD_EXIT = 16'hFFFF;
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_QUERY = 16'h0098;
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam int BUF_WORDS = 32;
  localparam int SB_READY = 7;
  localparam int SB_SUPPLY_ERR = 3;
  localparam int SB_LOCKED = 1;
  localparam int SB_BUSY = 0;
  localparam logic [7:0] Q_BASE = 8'h10;
  localparam logic [7:0] Q_SYSIF = 8'h1B;
  localparam logic [7:0] Q_GEOM = 8'h27;
  localparam logic [7:0] Q_EXT_PTR = 8'h15;
  localparam logic [15:0] Q_EXT_PTR_VAL = 16'h010A;
  localparam int PROG_TIME_NS = 50;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXIT_CYCLES = 4;
  typedef enum logic [1:0] {FFPQ_OUT_ARRAY, FFPQ_OUT_STATUS, FFPQ_OUT_QUERY} ffpq_out_t;
endpackage : ffpq_pkg

// ==== core/ffpq_query_rom.sv ====
// Query database lookup: word address in, 16-bit query word out.
// Assumes the caller registers the output.
`timescale 1ns/100ps
`default_nettype none
module ffpq_query_rom (
  input wire logic [7:0] qaddr,
  output logic [15:0] qdata
);
  import ffpq_pkg::*;
  logic [7:0] low_byte;
  // Identification, interface and geometry subsections; unknown offsets read zero
  always_comb begin
    low_byte = 8'h00;
    case (qaddr)
      Q_BASE: low_byte = 8'h51;
      8'h11: low_byte = 8'h52;
      8'h12: low_byte = 8'h59;
      8'h13: low_byte = 8'h01;
      Q_EXT_PTR: low_byte = Q_EXT_PTR_VAL[7:0];
      8'h16: low_byte = Q_EXT_PTR_VAL[15:8];
      Q_SYSIF: low_byte = 8'h17;
      8'h1C: low_byte = 8'h20;
      8'h1D: low_byte = 8'h85;
      8'h1E: low_byte = 8'h95;
      8'h1F: low_byte = 8'h08;
      8'h20: low_byte = 8'h09;
      8'h21: low_byte = 8'h0A;
      8'h23: low_byte = 8'h01;
      8'h24: low_byte = 8'h01;
      8'h25: low_byte = 8'h02;
      Q_GEOM: low_byte = 8'h00;
      8'h28: low_byte = 8'h01;
      8'h2A: low_byte = 8'h06;
      default: low_byte = 8'h00;
    endcase
  end
  // Upper lines always zero in query mode
  assign qdata = {8'h00, low_byte};
endmodule : ffpq_query_rom
`default_nettype wire

// ==== verification/ffpq_host_model.sv ====
// Host controller model: strobed writes and reads on the flash command bus.
// Assumes the bench calls its tasks; lines change at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module ffpq_host_model #(
  parameter int ADDR_W = 24
) (
  input wire logic clk_sys,
  output logic wr_en,
  output logic rd_en,
  output logic [ADDR_W-1:0] addr,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  import ffpq_pkg::*;
  // Bus idle at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = 16'h0000;
  end
  // Lines are inverted after release so a stale value never looks valid
  task automatic host_write(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(negedge clk_sys);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : host_write
  // Sampled two falling edges on, which covers either answer latency
  task automatic host_read(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(negedge clk_sys);
    rd_en <= 1'b0;
    addr <= ~a;
    @(negedge clk_sys);
    d = rdata;
  endtask : host_read
  // Setup then confirm, both at the aligned first word address
  task automatic ffp_start(input logic [ADDR_W-1:0] a);
    host_write(a, CMD_FFP);
    host_write(a, CMD_FFP);
  endtask : ffp_start
  // One whole buffer, every word to the first address, counted to the size
  task automatic ffp_load(input logic [ADDR_W-1:0] a, input logic [15:0] base);
    for (int n = 0; n < BUF_WORDS; n++) begin
      host_write(a, base + 16'(n));
    end
  endtask : ffp_load
endmodule : ffpq_host_model
`default_nettype wire

// ==== verification/flash_fast_program_query_tb.sv ====
// Bench for the fast-program sequencer and query database.
// Assumes the host model drives the bus; this module drives the levels.
`timescale 1ns/100ps
`default_nettype none
module flash_fast_program_query_tb;
  import ffpq_pkg::*;
  localparam logic [23:0] BASE_A = 24'h01_0040;
  localparam logic [15:0] ARR_V = 16'h3C5A;
  logic clk_sys = 1'b0;
  logic rst_n;
  logic supply_ok;
  logic locked;
  logic [15:0] array_rdata;
  logic wr_en;
  logic rd_en;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic array_we;
  logic [23:0] array_addr;
  logic [15:0] array_wdata;
  int failures = 0;
  int cmp_count = 0;
  int we_n = 0;
  logic [23:0] got_a [64];
  logic [15:0] got_d [64];
  always #5 clk_sys = ~clk_sys;
  ffpq_top #(.ADDR_W(24), .BLOCK_W(16)) ffpq_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .program_supply_high_level(supply_ok),
    .block_locked(locked), .array_rdata(array_rdata), .array_we(array_we), .array_addr(array_addr),
    .array_wdata(array_wdata));
  ffpq_host_model #(.ADDR_W(24)) ffpq_host_model_inst (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata));
  // Log each committed word; the count runs on past the log to expose extras
  always @(posedge clk_sys) begin
    if (array_we === 1'b1) begin
      if (we_n < 64) begin
        got_a[we_n] = array_addr;
        got_d[we_n] = array_wdata;
      end
      we_n++;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      failures++;
    end
  endtask : chk
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic do_reset(input logic sup, input logic lck);
    @(negedge clk_sys);
    rst_n = 1'b0;
    supply_ok = sup;
    locked = lck;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    we_n = 0;
  endtask : do_reset
  // Polls a status bit; a bounded wait, since a stuck bit would hang the host
  task automatic wait_bit(input int b, input logic v);
    logic [15:0] st;
    int k;
    k = 0;
    do begin
      ffpq_host_model_inst.host_read(BASE_A, st);
      k++;
    end while (st[b] !== v && k < 200);
    chk(16'(st[b]), 16'(v), "status bit wait");
  endtask : wait_bit
  task automatic t_query();
    logic [7:0] qa [6];
    logic [15:0] qd [6];
    logic [15:0] d;
    qa = '{8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h1B};
    qd = '{16'h0051, 16'h0052, 16'h0059, 16'h000A, 16'h0001, 16'h0017};
    do_reset(1'b1, 1'b0);
    ffpq_host_model_inst.host_write(24'h00_0000, CMD_QUERY);
    for (int i = 0; i < 6; i++) begin
      ffpq_host_model_inst.host_read(24'(qa[i]), d);
      chk(d, qd[i], "query word");
    end
    ffpq_host_model_inst.host_read(24'(Q_GEOM), d);
    chk(d & 16'hFF00, 16'h0000, "query upper byte");
    ffpq_host_model_inst.host_write(24'h00_0000, CMD_READ_ARRAY);
    ffpq_host_model_inst.host_read(24'h00_0010, d);
    chk(d, ARR_V, "array read after query");
    ffpq_host_model_inst.host_write(24'h00_0000, CMD_READ_STATUS);
    ffpq_host_model_inst.host_read(24'h00_0010, d);
    chk(d, 16'h0080, "status read while idle");
  endtask : t_query
  task automatic t_setup_err();
    logic [15:0] st;
    for (int i = 0; i < 2; i++) begin
      do_reset(i == 1, i == 1);
      ffpq_host_model_inst.ffp_start(BASE_A);
      ffpq_host_model_inst.host_read(BASE_A, st);
      chk(st & 16'h008A, (i == 1) ? 16'h0082 : 16'h0088, "setup error status");
    end
  endtask : t_setup_err
  task automatic t_program();
    logic [15:0] st;
    do_reset(1'b1, 1'b0);
    ffpq_host_model_inst.ffp_start(BASE_A);
    ffpq_host_model_inst.host_read(BASE_A, st);
    chk(st & 16'h0081, 16'h0000, "ready status");
    ffpq_host_model_inst.ffp_load(BASE_A, 16'hA500);
    ffpq_host_model_inst.host_write(BASE_A, 16'hDEAD);
    ffpq_host_model_inst.host_read(BASE_A, st);
    chk(st & 16'h0001, 16'h0001, "busy status");
    wait_bit(0, 1'b0);
    chk(16'(we_n), 16'h0020, "words committed");
    for (int n = 0; n < 32; n++) begin
      chk(got_a[n][15:0], BASE_A[15:0] + 16'(n), "word address");
      chk(got_d[n], 16'hA500 + 16'(n), "word data");
    end
    ffpq_host_model_inst.ffp_load(BASE_A, 16'hB500);
    wait_bit(0, 1'b0);
    chk(16'(we_n), 16'h0040, "second buffer count");
    chk(got_d[32], 16'hB500, "second buffer data");
    ffpq_host_model_inst.host_write(24'h02_0000, CMD_EXIT);
    ffpq_host_model_inst.host_read(BASE_A, st);
    chk(st & 16'h0080, 16'h0000, "exit pending");
    wait_bit(7, 1'b1);
    ffpq_host_model_inst.host_write(BASE_A, CMD_READ_ARRAY);
    ffpq_host_model_inst.host_read(BASE_A, st);
    chk(st, ARR_V, "array read after exit");
  endtask : t_program
  // Watchdog sized well beyond the several hundred cycles the run needs
  initial begin
    #200_000;
    failures++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    supply_ok = 1'b1;
    locked = 1'b0;
    array_rdata = ARR_V;
    t_query();
    t_setup_err();
    t_program();
    test_done();
  end
endmodule : flash_fast_program_query_tb
`default_nettype wire
